// ### logic/det_sync.sv
`timescale 1ns/1ps
// Purpose: two-flop synchroniser for asynchronous detector levels
// Assumes: levels, not pulses
// Notes:   first stage read only by second stage
module det_sync (
    input  wire logic core_clk_i,
    input  wire logic nrst_i,
    sync_if.syn       s
);
    typedef struct packed {
        logic [4:0] meta;
        logic [4:0] stable;
    } sync_state_t;
    sync_state_t st, next_st;

    // shift raw levels through two stages
    always_comb begin
        next_st        = st;
        next_st.meta   = s.raw;
        next_st.stable = st.meta;
    end
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign s.synced = st.stable;
endmodule // det_sync

// ### logic/diag_pkg.sv
// Purpose: shared constants for the switch diagnostic status logic
// Assumes: core clock at 200 MHz
// Notes:   times kept in microseconds, cycle counts derived from them
package diag_pkg;
    localparam int unsigned CLK_MHZ       = 200;
    localparam int unsigned OL_BLANK_US   = 130;   // open_load_blanking_time
    localparam int unsigned SW_OFF_TO_US  = 260;   // switch_off_timeout (worst case)
    localparam int unsigned ST_RESET_US   = 120;   // status_reset_blanking_time
    localparam int unsigned OV_BLANK_US   = 10;    // overvoltage_blanking_time, plain default
    localparam int unsigned OL_BLANK_CYC  = OL_BLANK_US * CLK_MHZ;
    localparam int unsigned SW_OFF_TO_CYC = SW_OFF_TO_US * CLK_MHZ;
    localparam int unsigned ST_RESET_CYC  = ST_RESET_US * CLK_MHZ;
    localparam int unsigned OV_BLANK_CYC  = OV_BLANK_US * CLK_MHZ;
    localparam int unsigned CNT_W         = 17;
    localparam logic [1:0]  SENSE_OFF     = 2'h0;
    localparam logic [1:0]  SENSE_PROP    = 2'h1;
    localparam logic [1:0]  SENSE_FAULT   = 2'h2;
endpackage

// ### logic/switch_diag.sv
`timescale 1ns/1ps
// Purpose: diagnostic status logic of a single-channel high-side switch
// Assumes: detector inputs asynchronous, control inputs synchronous
// Notes:   open-drain fault_flag_pin as out/oe pair, driven value always 0
//
// Behaviour
// - in on state basic detectors continuously drive status level
// - overvoltage lockout evaluated in both on and off states
// - status is open drain: released high normally, pulled low on fault
// - on state: short, overtemp, lockout, resistance fault pull status low
// - off state, enable low: only lockout reported
// - off-state open load only reported with enable high
// - open load flag needs uninterrupted blanking time; break restarts
// - blanking restarts on each enable rise except right after switch-off
// - after channel falls, blanking starts only after switch-off timeout
// - open load from comparator near supply, flag after blanking time
// - limit current fault low while enable low, masked while high
// - enable rise with limit fault: hold low for reset blanking time
// - off state enable high: short-to-supply and overtemp pull low
// - off state enable low: non-lockout faults leave status high
// - off-state open load and short-to-supply clear immediately
// - lockout after overvoltage blanking, stage off, auto restart
// - on-state overtemp turns stage off, auto restart when cooled
// - enable high: sense carries fault current in overload until stop
// - open load blanking time 130 us
// - switch-off timeout 195 us typical, 260 us max
// - status reset blanking time 120 us
module switch_diag
    import diag_pkg::*;
#(
    parameter int unsigned OL_CYC  = OL_BLANK_CYC,
    parameter int unsigned TO_CYC  = SW_OFF_TO_CYC,
    parameter int unsigned RST_CYC = ST_RESET_CYC,
    parameter int unsigned OV_CYC  = OV_BLANK_CYC
) (
    input  wire logic       core_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       channel_in_i,
    input  wire logic       diag_enable_i,
    input  wire logic       overload_i,
    input  wire logic       overtemp_i,
    input  wire logic       overvoltage_i,
    input  wire logic       open_load_cmp_i,
    input  wire logic       limit_set_short_i,
    output logic            fault_flag_pin_o,
    output logic            fault_flag_pin_oe_o,
    output logic            power_stage_on_o,
    output logic [1:0]      sense_output_o
);
    ////////////////////////////////////////////////////////////////////////
    // detector synchronisation
    sync_if det ();
    assign det.raw = {limit_set_short_i, open_load_cmp_i, overvoltage_i,
                      overtemp_i, overload_i};
    det_sync u_sync (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .s          (det)
    );

    logic ovl_s, ot_s, ov_s, olc_s, lim_s;
    assign ovl_s = det.synced[0];
    assign ot_s  = det.synced[1];
    assign ov_s  = det.synced[2];
    assign olc_s = det.synced[3];
    assign lim_s = det.synced[4];

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef enum logic [1:0] {
        OFF_WAIT_TO,
        OFF_STABLE,
        CH_ON
    } ch_state_t;

    typedef struct packed {
        ch_state_t          ch;
        logic [CNT_W-1:0]   to_cnt;
        logic [CNT_W-1:0]   ol_cnt;
        logic               ol_run;
        logic [CNT_W-1:0]   ov_cnt;
        logic               overvoltage_lockout;
        logic [CNT_W-1:0]   rst_cnt;
        logic               lim_hold;
        logic               den_d;
        logic               ol_flag;
        logic               fault_low;
        logic               stage_on;
        logic [1:0]         sense;
    } diag_state_t;

    diag_state_t st, next_st;

    localparam logic [CNT_W-1:0] OL_LAST  = CNT_W'(OL_CYC - 1);
    localparam logic [CNT_W-1:0] TO_LAST  = CNT_W'(TO_CYC - 1);
    localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RST_CYC - 1);
    localparam logic [CNT_W-1:0] OV_LAST  = CNT_W'(OV_CYC - 1);

    logic den_rise;
    logic off_qual;
    logic lim_flag;
    assign den_rise = diag_enable_i & ~st.den_d;
    // open-load comparator serves short-to-supply too; the pull circuit picks which
    assign off_qual = olc_s;

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        next_st       = st;
        next_st.den_d = diag_enable_i;
        lim_flag      = 1'b0;

        // overvoltage blanking then lockout, auto restart on clear
        if (ov_s) begin
            if (st.ov_cnt == OV_LAST) begin
                next_st.overvoltage_lockout = 1'b1;
            end else begin
                next_st.ov_cnt = st.ov_cnt + 1'b1;
            end
        end else begin
            next_st.ov_cnt = '0;
            next_st.overvoltage_lockout   = 1'b0;
        end

        // channel state and switch-off timeout
        case (st.ch)
            CH_ON: begin
                if (!channel_in_i) begin
                    next_st.ch     = OFF_WAIT_TO;
                    next_st.to_cnt = '0;
                end
            end
            OFF_WAIT_TO: begin
                if (channel_in_i) begin
                    next_st.ch = CH_ON;
                end else if (st.to_cnt == TO_LAST) begin
                    next_st.ch = OFF_STABLE;
                end else begin
                    next_st.to_cnt = st.to_cnt + 1'b1;
                end
            end
            OFF_STABLE: begin
                if (channel_in_i) begin
                    next_st.ch = CH_ON;
                end
            end
            default: begin
                next_st.ch = OFF_STABLE;
            end
        endcase

        // open-load / short-to-supply blanking in stable off state
        if (st.ch != OFF_STABLE || !diag_enable_i || !off_qual) begin
            next_st.ol_cnt  = '0;
            next_st.ol_run  = 1'b0;
            next_st.ol_flag = 1'b0;
        end else if (den_rise) begin
            next_st.ol_cnt  = '0;
            next_st.ol_run  = 1'b1;
            next_st.ol_flag = 1'b0;
        end else if (!st.ol_flag) begin
            next_st.ol_run = 1'b1;
            if (st.ol_cnt == OL_LAST) begin
                next_st.ol_flag = 1'b1;
            end else begin
                next_st.ol_cnt = st.ol_cnt + 1'b1;
            end
        end

        // limit-set resistor fault: mask with enable, reset blanking on rise
        if (st.ch == CH_ON && lim_s && diag_enable_i && den_rise) begin
            next_st.lim_hold = 1'b1;
            next_st.rst_cnt  = '0;
        end else if (st.lim_hold) begin
            if (st.rst_cnt == RST_LAST || st.ch != CH_ON) begin
                next_st.lim_hold = 1'b0;
            end else begin
                next_st.rst_cnt = st.rst_cnt + 1'b1;
            end
        end
        // next hold joins in so the line does not blink high on the enable edge
        lim_flag = next_st.lim_hold | st.lim_hold | (lim_s & ~diag_enable_i);

        // power stage: off on lockout or overtemp, restarts when cleared
        next_st.stage_on = (next_st.ch == CH_ON) & ~next_st.overvoltage_lockout & ~ot_s;

        // status level selection
        if (st.ch == CH_ON) begin
            next_st.fault_low = ovl_s | ot_s | st.overvoltage_lockout | lim_flag;
        end else if (diag_enable_i) begin
            next_st.fault_low = st.overvoltage_lockout | ot_s | st.ol_flag;
        end else begin
            next_st.fault_low = st.overvoltage_lockout;
        end

        // sense output selection
        if (st.ch != CH_ON || !diag_enable_i || !next_st.stage_on) begin
            next_st.sense = SENSE_OFF;
        end else if (ovl_s) begin
            next_st.sense = SENSE_FAULT;
        end else begin
            next_st.sense = SENSE_PROP;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '{ch: OFF_STABLE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // open drain: drive zero only while flagging
    assign fault_flag_pin_o    = 1'b0;
    assign fault_flag_pin_oe_o = st.fault_low;
    assign power_stage_on_o    = st.stage_on;
    assign sense_output_o      = st.sense;
endmodule // switch_diag

// ### logic/sync_if.sv
`timescale 1ns/1ps
// Purpose: carries raw and synchronised detector levels between modules
// Assumes: one clock domain
// Notes:   five detector lines
interface sync_if;
    logic [4:0] raw;
    logic [4:0] synced;
    modport src (output raw, input synced);
    modport syn (input raw, output synced);
endinterface

// ### test/diag_ctrl_model.sv
// Purpose: controller side of the status line and the load pulls
// Assumes: pull-up to logic supply on the status line
// Notes:   an illegal pull pair is flagged, not resolved
`timescale 1ns/1ps
module diag_ctrl_model (
    input  wire logic fault_flag_pin_i,
    input  wire logic fault_flag_pin_oe_i,
    input  wire logic pull_up_en_i,
    input  wire logic pull_down_en_i,
    input  wire logic load_open_i,
    input  wire logic out_short_i,
    output logic      status_line_o,
    output logic      open_load_cmp_o,
    output logic      pull_clash_o
);
    // line floats to the pull-up unless the drain sinks it
    assign status_line_o = fault_flag_pin_oe_i ? fault_flag_pin_i : 1'b1;
    // output sits near supply when shorted, or pulled up with no load
    assign open_load_cmp_o = out_short_i || (pull_up_en_i && load_open_i);
    // both pulls at once would mask each other
    assign pull_clash_o = pull_up_en_i && pull_down_en_i;
endmodule // diag_ctrl_model

// ### test/switch_diag_asserts.sv
// Purpose: concurrent checks on the switch_diag ports
// Assumes: detector levels held several cycles by the bench
// Notes:   bounds allow for the two-flop detector latency
`timescale 1ns/1ps
module switch_diag_asserts
    import diag_pkg::*;
#(
    parameter int unsigned OL_CYC = 8,
    parameter int unsigned OV_CYC = 6
) (
    input wire logic       core_clk_i,
    input wire logic       nrst_i,
    input wire logic       channel_in_i,
    input wire logic       diag_enable_i,
    input wire logic       overload_i,
    input wire logic       overtemp_i,
    input wire logic       overvoltage_i,
    input wire logic       open_load_cmp_i,
    input wire logic       limit_set_short_i,
    input wire logic       fault_flag_pin_o,
    input wire logic       fault_flag_pin_oe_o,
    input wire logic       power_stage_on_o,
    input wire logic [1:0] sense_output_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    logic [7:0] ov_cnt;
    logic [7:0] ol_cnt;
    ////////////////////////////////////////////////////////////////////////////////
    // run lengths of raw levels, saturating so long runs never wrap
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ov_cnt <= 8'h00;
            ol_cnt <= 8'h00;
        end else begin
            ov_cnt <= overvoltage_i ? ov_cnt + {7'h00, ov_cnt != 8'hff} : 8'h00;
            ol_cnt <= open_load_cmp_i ? ol_cnt + {7'h00, ol_cnt != 8'hff} : 8'h00;
        end
    end
    // limit fault seen with channel on, enable low and no overload
    sequence s_lim_flagged;
        (channel_in_i && !diag_enable_i && limit_set_short_i && !overload_i)[*5];
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_drive_zero: assert property (fault_flag_pin_o == 1'b0)
        else $error("status data bit not zero");
    a_off_quiet: assert property ((!channel_in_i && !overvoltage_i && (!diag_enable_i
        || (!open_load_cmp_i && !overtemp_i)))[*5] |-> !fault_flag_pin_oe_o)
        else $error("status pulled low in quiet off state");
    a_short_on: assert property ((channel_in_i && overload_i)[*5] |-> fault_flag_pin_oe_o)
        else $error("overload not flagged");
    a_ot_on: assert property ((channel_in_i && overtemp_i)[*5]
        |-> fault_flag_pin_oe_o && !power_stage_on_o)
        else $error("overtemp not handled");
    a_sense_fault: assert property ((channel_in_i && diag_enable_i && overload_i
        && !overtemp_i && !overvoltage_i)[*5] |-> sense_output_o == SENSE_FAULT)
        else $error("sense not on fault current");
    a_limit_low: assert property (s_lim_flagged |-> fault_flag_pin_oe_o)
        else $error("limit fault not flagged");
    a_limit_hold: assert property (s_lim_flagged ##1 $rose(diag_enable_i)
        |-> fault_flag_pin_oe_o[*8] ##[1:8] !fault_flag_pin_oe_o)
        else $error("limit flag hold wrong");
    a_ov_lock: assert property (ov_cnt >= OV_CYC + 5
        |-> fault_flag_pin_oe_o && !power_stage_on_o)
        else $error("lockout not engaged");
    a_ol_blank: assert property ($rose(fault_flag_pin_oe_o) && !channel_in_i && diag_enable_i
        && !overtemp_i && !overvoltage_i |-> ol_cnt >= OL_CYC)
        else $error("open load flagged before blanking");
endmodule // switch_diag_asserts

bind switch_diag switch_diag_asserts #(.OL_CYC(OL_CYC), .OV_CYC(OV_CYC)) u_chk (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .channel_in_i(channel_in_i),
    .diag_enable_i(diag_enable_i), .overload_i(overload_i), .overtemp_i(overtemp_i),
    .overvoltage_i(overvoltage_i), .open_load_cmp_i(open_load_cmp_i),
    .limit_set_short_i(limit_set_short_i), .fault_flag_pin_o(fault_flag_pin_o),
    .fault_flag_pin_oe_o(fault_flag_pin_oe_o), .power_stage_on_o(power_stage_on_o),
    .sense_output_o(sense_output_o));

// ### test/tb_switch_diag.sv
// Purpose: self-checking bench for switch_diag
// Assumes: short blanking counts for simulation
// Notes:   results are checked one cycle after being noted
`timescale 1ns/1ps
module tb_switch_diag;
    import diag_pkg::*;
    localparam int unsigned OL = 8;
    localparam int unsigned TO = 12;
    localparam int unsigned RB = 10;
    localparam int unsigned OV = 6;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic ch = 1'b0, en = 1'b0, ovl = 1'b0, ot = 1'b0, ovv = 1'b0, lim = 1'b0;
    logic pu = 1'b0, pd = 1'b0, lo = 1'b0, sh = 1'b0;
    logic fd, foe, stage, st_line, ol_cmp, clash;
    logic [1:0] sense;
    logic [3:0] q[$];
    int failures = 0, cmp_count = 0, seed = 32'h8797fb3c;
    ////////////////////////////////////////////////////////////////////////////////
    switch_diag #(.OL_CYC(OL), .TO_CYC(TO), .RST_CYC(RB), .OV_CYC(OV)) i_switch_diag (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .channel_in_i(ch), .diag_enable_i(en),
        .overload_i(ovl), .overtemp_i(ot), .overvoltage_i(ovv), .open_load_cmp_i(ol_cmp),
        .limit_set_short_i(lim), .fault_flag_pin_o(fd), .fault_flag_pin_oe_o(foe),
        .power_stage_on_o(stage), .sense_output_o(sense));
    diag_ctrl_model i_diag_ctrl_model (.fault_flag_pin_i(fd), .fault_flag_pin_oe_i(foe),
        .pull_up_en_i(pu), .pull_down_en_i(pd), .load_open_i(lo), .out_short_i(sh),
        .status_line_o(st_line), .open_load_cmp_o(ol_cmp), .pull_clash_o(clash));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    // note the expected line, stage and sense, checked at the next edge
    task automatic chk(logic s, logic p, logic [1:0] m);
        q.push_back({s, p, m});
        cyc(1);
    endtask
    task automatic cmp_out(logic [3:0] e);
        cmp_count++;
        if ({st_line, stage, sense} !== e) begin
            failures++;
            $display("MISMATCH %0t got %b want %b", $time, {st_line, stage, sense}, e);
        end
        if (clash !== 1'b0) begin
            failures++;
            $display("MISMATCH %0t both load pulls enabled", $time);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // clock, and the watcher taking the oldest note after outputs settle
    initial forever #2.5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        if (q.size() != 0) begin
            #2;
            cmp_out(q.pop_front());
        end
    end
    // watchdog well beyond the few hundred cycles of the sequence
    initial begin
        #(5 * 2000);
        failures++;
        conclude();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge core_clk_i);
        #1 nrst_i = 1'b1;
        chk(1'b1, 1'b0, SENSE_OFF);
        en = 1'($random(seed));
        ch = 1'b1;
        cyc(4);
        chk(1'b1, 1'b1, en ? SENSE_PROP : SENSE_OFF);
        ovl = 1'b1;
        cyc(6);
        chk(1'b0, 1'b1, en ? SENSE_FAULT : SENSE_OFF);
        ovl = 1'b0;
        ot = 1'b1;
        cyc(6);
        chk(1'b0, 1'b0, SENSE_OFF);
        ot = 1'b0;
        en = 1'b0;
        lim = 1'b1;
        cyc(6);
        chk(1'b0, 1'b1, SENSE_OFF);
        en = 1'b1;
        cyc(RB - 3);
        chk(1'b0, 1'b1, SENSE_PROP);
        cyc(6);
        chk(1'b1, 1'b1, SENSE_PROP);
        en = 1'b0;
        cyc(4);
        chk(1'b0, 1'b1, SENSE_OFF);
        lim = 1'b0;
        ch = 1'b0;
        pu = 1'b1; // pull-down stays off while the pull-up is in use
        lo = 1'b1;
        cyc(TO + OL + 8);
        chk(1'b1, 1'b0, SENSE_OFF);
        en = 1'b1;
        cyc(OL / 2);
        chk(1'b1, 1'b0, SENSE_OFF);
        lo = 1'b0;
        cyc(3);
        lo = 1'b1;
        cyc(OL - 2);
        chk(1'b1, 1'b0, SENSE_OFF);
        cyc(6);
        chk(1'b0, 1'b0, SENSE_OFF);
        lo = 1'b0;
        cyc(3);
        chk(1'b1, 1'b0, SENSE_OFF);
        ch = 1'b1;
        lo = 1'b1;
        cyc(4);
        ch = 1'b0;
        cyc(TO);
        chk(1'b1, 1'b0, SENSE_OFF);
        cyc(OL + 6);
        chk(1'b0, 1'b0, SENSE_OFF);
        lo = 1'b0;
        pu = 1'b0;
        pd = 1'b1;
        sh = 1'b1;
        cyc(OL + 6);
        chk(1'b0, 1'b0, SENSE_OFF);
        sh = 1'b0;
        cyc(3);
        chk(1'b1, 1'b0, SENSE_OFF);
        ot = 1'b1;
        cyc(5);
        chk(1'b0, 1'b0, SENSE_OFF);
        en = 1'b0;
        cyc(3);
        chk(1'b1, 1'b0, SENSE_OFF);
        ot = 1'b0;
        ovv = 1'b1;
        cyc(OV + 8);
        chk(1'b0, 1'b0, SENSE_OFF);
        ovv = 1'b0;
        ch = 1'b1;
        cyc(6);
        ovv = 1'b1;
        cyc(2);
        chk(1'b1, 1'b1, SENSE_OFF);
        cyc(OV + 6);
        chk(1'b0, 1'b0, SENSE_OFF);
        ovv = 1'b0;
        cyc(6);
        chk(1'b1, 1'b1, SENSE_OFF);
        cyc(2);
        conclude();
    end
endmodule // tb_switch_diag
